// ---- pkg/i2cam_pkg.sv ----
// i2cam_pkg: register map, field positions, reset values, timing and carrier types
// of the two-wire address/data block; shared by every design file of the block except i2cam_pin_sync.
// assumes a 100 MHz core clock and an 8-bit register port.
package i2cam_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets on the plain register port
  localparam logic [4:0] OFS_ADDR_FMT = 5'h00;
  localparam logic [4:0] OFS_TX_DATA  = 5'h04;
  localparam logic [4:0] OFS_RX_DATA  = 5'h08;
  localparam logic [4:0] OFS_STATUS   = 5'h0C;
  localparam logic [4:0] OFS_CTL_ONE  = 5'h10;
  localparam logic [4:0] OFS_CTL_TWO  = 5'h14;
  localparam logic [4:0] OFS_MODE     = 5'h18;
  localparam logic [4:0] OFS_IRQ_EN   = 5'h1C;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int FMT_SEL_BIT    = 0;
  localparam int ADDR_MSB       = 7;
  localparam int ADDR_LSB       = 1;
  localparam int ST_TX_EMPTY    = 7;
  localparam int ST_TX_DONE     = 6;
  localparam int ST_RX_FULL     = 5;
  localparam int ST_NO_ACK      = 4;
  localparam int ST_STOP        = 3;
  localparam int ST_ADDR_MATCH  = 1;
  localparam int ST_GEN_CALL    = 0;
  localparam int C1_ENABLE      = 7;
  localparam int C1_MASTER      = 5;
  localparam int C1_TRANSMIT    = 4;
  localparam int C2_BUSY        = 7;
  localparam int C2_START_STOP  = 6;
  localparam int MODE_BIT_ORDER = 3;
  localparam int IEN_ACK_CHECK  = 0;
  localparam int IEN_RX_ACK     = 1;

  // status bits that software may clear by writing 0
  localparam logic [7:0] ST_SW_CLR_MASK = 8'h7B;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and fixed codes
  localparam logic [7:0] ADDR_FMT_RESET = 8'h00;
  localparam logic [7:0] TX_DATA_RESET  = 8'hFF;
  localparam logic [7:0] RX_DATA_RESET  = 8'hFF;
  localparam logic [6:0] GEN_CALL_ADDR  = 7'h00;
  localparam logic [3:0] FRAME_BITS     = 4'h8;
  localparam logic [3:0] LAST_BIT       = 4'h7;

  ////////////////////////////////////////////////////////////////////////////
  // timing: half an SCL period, least time so rounded up
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_HALF_NS   = 5000;
  localparam int SCL_HALF_CYC  = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] SCL_HALF_RELOAD = 10'(SCL_HALF_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // carriers and states
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } i2cam_req_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic busy;
  } i2cam_evt_t;

  typedef enum logic [9:0] {
    M_IDLE     = 10'h001,
    M_START    = 10'h002,
    M_HOLD     = 10'h004,
    M_BIT_LO   = 10'h008,
    M_BIT_HI   = 10'h010,
    M_ACK_LO   = 10'h020,
    M_ACK_HI   = 10'h040,
    M_STOP_LO  = 10'h080,
    M_STOP_HI  = 10'h100,
    M_STOP_REL = 10'h200
  } i2cam_mst_t;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_ADDR = 5'h02,
    S_DATA = 5'h04,
    S_ACK  = 5'h08,
    S_SKIP = 5'h10
  } i2cam_slv_t;

  // mirror a byte end for end
  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction : rev8

endpackage : i2cam_pkg

// ---- tb/i2cam_slave_bfm.sv ----
// i2cam_slave_bfm: far-side slave, acknowledges each byte after a start while nack is low
// assumes the bench resolves the wired-and pins
`timescale 1ns/1ps
`default_nettype none
module i2cam_slave_bfm (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic nack,
  output var logic  ack_oe
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] fall_q;
  ////////////////////////////////////////
  // count SCL falls since start; pull SDA from 9th to 10th fall
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      fall_q <= 4'h0;
      ack_oe <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda) begin
        fall_q <= 4'h0;
      end else if (scl_q && !scl) begin
        fall_q <= (fall_q == 4'h9) ? 4'h1 : fall_q + 4'h1;
        ack_oe <= (fall_q == 4'h8) && !nack;
      end
    end
  end
endmodule : i2cam_slave_bfm
`default_nettype wire

// ---- tb/i2cam_top_monitor.sv ----
// i2cam_top_monitor: port-level assertions on the two-wire block
// assumes it is bound onto i2cam_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module i2cam_top_monitor (
  input wire logic                  core_clk,
  input wire logic                  rst,
  input wire i2cam_pkg::i2cam_req_t req,
  input wire logic [7:0]            rdata,
  input wire logic                  scl_in,
  input wire logic                  scl_out,
  input wire logic                  scl_oe,
  input wire logic                  sda_in,
  input wire logic                  sda_out,
  input wire logic                  sda_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // read port, open-drain pins, phase lengths; phases are 500 cycles, 8 is a safe floor
  a_rdata_idle_zero: assert property (!$past(req.rd) |-> rdata == 8'h00) else $error("stray read data");
  a_pins_drive_low: assert property (scl_out == 1'b0 && sda_out == 1'b0) else $error("pin driven high");
  a_start_scl_high: assert property ($rose(sda_oe) && !scl_oe && scl_in |-> !scl_oe [*8]) else $error("short start");
  a_ack_held: assert property ($rose(sda_oe) && !scl_oe && !scl_in |-> sda_oe [*8]) else $error("ack dropped");
  a_scl_low_len: assert property ($rose(scl_oe) |-> scl_oe [*8]) else $error("short low phase");
  a_scl_high_len: assert property ($fell(scl_oe) |-> !scl_oe [*8]) else $error("short high phase");
  a_stop_scl_high: assert property ($fell(sda_oe) && !scl_oe && scl_in |-> $past(scl_in, 3)) else $error("bad stop");
  a_ctl_scp_zero: assert property ($past(req.rd) && $past(req.addr) == 5'h14 |-> !rdata[6]) else $error("scp read 1");
endmodule : i2cam_top_monitor
bind i2cam_top i2cam_top_monitor mon_u (.core_clk(core_clk), .rst(rst), .req(req), .rdata(rdata), .scl_in(scl_in),
  .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));
`default_nettype wire

// ---- tb/i2cam_top_tb_top.sv ----
// i2cam_top_tb_top: register, master and slave scenarios for the two-wire block
// assumes the slave model and the bound monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module i2cam_top_tb_top;
  logic                  core_clk;
  logic                  rst = 1'b1;
  i2cam_pkg::i2cam_req_t req = '0;
  logic [7:0]            rdata, rv, nst = 8'h00, nsp = 8'h00;
  logic [15:0]           cap;
  logic                  scl_oe, sda_oe, ack_oe, tscl = 1'b0, tsda = 1'b0, nack = 1'b0;
  int                    fails = 0, n_checks = 0;
  wire                   scl = !(scl_oe || tscl);
  wire                   sda = !(sda_oe || ack_oe || tsda);
  logic [7:0]            sb [3] = '{8'hA4, 8'h00, 8'h44};
  logic [1:0]            ss [3] = '{2'h2, 2'h3, 2'h0};
  logic                  sa [3] = '{1'b0, 1'b0, 1'b1};
  i2cam_top dut_u (.core_clk(core_clk), .rst(rst), .req(req), .rdata(rdata), .scl_in(scl), .scl_out(),
                   .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe));
  i2cam_slave_bfm bfm_u (.core_clk(core_clk), .rst(rst), .scl(scl), .sda(sda), .nack(nack), .ack_oe(ack_oe));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // wire watch; start and stop judged 1 ns late so paired pin moves do not count
  always @(posedge scl) cap = {cap[14:0], sda};
  always @(negedge sda) #1 if (scl === 1'b1 && !rst) nst++;
  always @(posedge sda) #1 if (scl === 1'b1 && !rst) nsp++;
  ////////////////////////////////////////
  task automatic rw(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk);
    req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge core_clk);
    req <= '0;
    #1 rv = rdata;
  endtask : rw
  task automatic report_and_stop();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  // status poll, bounded; a miss ends the run
  task automatic poll(input int b);
    int i;
    for (i = 0; i < 4000; i++) begin
      rw(1'b0, 5'h0C, 8'h00);
      if (rv[b] === 1'b1) break;
      repeat (8) @(posedge core_clk);
    end
    if (i == 4000) begin
      fails++;
      report_and_stop();
    end
  endtask : poll
  task automatic pin(input logic c, input logic d);
    tscl <= c;
    tsda <= d;
    repeat (20) @(posedge core_clk);
  endtask : pin
  // bench as bus master: start, byte, ninth clock, stop; one pin moves per step
  task automatic mbyte(input logic [7:0] b);
    pin(1'b0, 1'b1);
    pin(1'b1, 1'b1);
    for (int i = 7; i >= 0; i--) begin
      pin(1'b1, !b[i]);
      pin(1'b0, !b[i]);
      pin(1'b1, !b[i]);
    end
    pin(1'b1, 1'b0);
    pin(1'b0, 1'b0);
    pin(1'b1, 1'b0);
    pin(1'b1, 1'b1);
    pin(1'b0, 1'b1);
    pin(1'b0, 1'b0);
  endtask : mbyte
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rw(1'b0, 5'h00, 8'h00);
    `CHK(rv, 8'h00)
    rw(1'b0, 5'h04, 8'h00);
    `CHK(rv, 8'hFF)
    rw(1'b1, 5'h08, 8'h12);
    rw(1'b0, 5'h08, 8'h00);
    `CHK(rv, 8'hFF)
    rw(1'b1, 5'h0C, 8'hFF);
    rw(1'b0, 5'h0C, 8'h00);
    `CHK(rv, 8'h00)
    rw(1'b1, 5'h00, 8'h33);
    rw(1'b0, 5'h00, 8'h00);
    `CHK(rv, 8'h33)
    rw(1'b1, 5'h00, 8'h00);
    // master transmit: acked address byte, then a refused data byte
    rw(1'b1, 5'h10, 8'hB0);
    rw(1'b1, 5'h14, 8'h80);
    poll(7);
    rw(1'b1, 5'h04, 8'hA4);
    poll(6);
    `CHK(rv[7], 1'b1)
    `CHK(cap[8:0], 9'h148)
    rw(1'b0, 5'h14, 8'h00);
    `CHK(rv[7], 1'b1)
    repeat (510) @(posedge core_clk);
    rw(1'b0, 5'h1C, 8'h00);
    `CHK(rv[1], 1'b0)
    rw(1'b1, 5'h1C, 8'h01);
    nack = 1'b1;
    rw(1'b1, 5'h04, 8'h3C);
    poll(4);
    `CHK(cap[8:0], 9'h079)
    rw(1'b0, 5'h1C, 8'h00);
    `CHK(rv[1], 1'b1)
    rw(1'b1, 5'h14, 8'h00);
    poll(3);
    `CHK(rv, 8'hD8)
    rw(1'b0, 5'h10, 8'h00);
    `CHK(rv, 8'h80)
    `CHK(nst, 8'h01)
    `CHK(nsp, 8'h01)
    rw(1'b1, 5'h0C, 8'h00);
    rw(1'b0, 5'h0C, 8'h00);
    `CHK(rv, 8'h80)
    // slave: own address, general call, foreign address
    rw(1'b1, 5'h00, 8'hA4);
    rw(1'b1, 5'h10, 8'h80);
    for (int k = 0; k < 3; k++) begin
      mbyte(sb[k]);
      `CHK(cap[1], sa[k])
      rw(1'b0, 5'h0C, 8'h00);
      `CHK(rv[1:0], ss[k])
      rw(1'b1, 5'h0C, 8'h00);
    end
    rw(1'b0, 5'h08, 8'h00);
    `CHK(rv, 8'h00)
    rw(1'b1, 5'h18, 8'h08);
    rw(1'b1, 5'h04, 8'h1E);
    rw(1'b0, 5'h04, 8'h00);
    `CHK(rv, 8'h78)
    report_and_stop();
  end
endmodule : i2cam_top_tb_top
`default_nettype wire

// ---- verilog/i2cam_bus_mon.sv ----
// i2cam_bus_mon: watches synchronised SCL/SDA for start, stop and clock edges,
// and tracks whether the bus is taken. assumes synchronised inputs.
`timescale 1ns/1ps
`default_nettype none
module i2cam_bus_mon (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              scl_s,
  input  wire logic              sda_s,
  output var i2cam_pkg::i2cam_evt_t evt
);
  logic scl_q;
  logic sda_q;
  logic busy_q;
  logic start_w;
  logic stop_w;

  // conditions are SDA moving while SCL stays high
  assign start_w = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_w  = scl_s & scl_q & ~sda_q & sda_s;

  assign evt.start    = start_w;
  assign evt.stop     = stop_w;
  assign evt.scl_rise = scl_s & ~scl_q;
  assign evt.scl_fall = ~scl_s & scl_q;
  assign evt.busy     = busy_q;

  // previous levels and busy tracking
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      scl_q  <= scl_s;
      sda_q  <= sda_s;
      busy_q <= start_w | (busy_q & ~stop_w);
    end
  end
endmodule : i2cam_bus_mon
`default_nettype wire

// ---- verilog/i2cam_pin_sync.sv ----
// i2cam_pin_sync: two-stage synchroniser for the SCL and SDA pin levels.
// assumes the pins idle high through external pull-ups.
`timescale 1ns/1ps
`default_nettype none
module i2cam_pin_sync (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_s,
  output logic      sda_s
);
  logic [1:0] meta_q;

  // first stage feeds only the second; idle-high reset avoids a false start
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_q <= 2'h3;
      scl_s  <= 1'b1;
      sda_s  <= 1'b1;
    end else begin
      meta_q <= {scl_in, sda_in};
      scl_s  <= meta_q[1];
      sda_s  <= meta_q[0];
    end
  end
endmodule : i2cam_pin_sync
`default_nettype wire

// ---- verilog/i2cam_top.sv ----
// i2cam_top: two-wire bus block with master transmit, slave address match,
// data holding registers and flag status, reached over a plain register port.
// assumes open-drain pins with pull-ups and a 100 MHz core clock.
//
// Operation
// - own address or general call sets match
// - match flag cleared by zero after read
// - general call flag set, cleared likewise
// - writing one never sets a flag
// - compare seven address bits in slave mode
// - bit 0 format, bits 7-1 address
// - tx holding resets FF, feeds empty shifter
// - new byte accepted while shifter busy
// - bit order set returns reversed byte
// - rx holding resets FF, loads per byte
// - shifter hidden from software
// - first frame is address plus direction
// - start is SDA falling, SCL high
// - stop is SDA rising, SCL high
// - direction one reads, zero writes
// - receiver pulls SDA low on ninth clock
// - busy one, control zero issues start
// - tx write clears empty, load sets it
// - done flag on ninth rise if empty
// - ack bit one means no acknowledge
// - SCL held low awaiting data or stop
// - stop after master transfer reverts slave
// - no-ack flag when checking enabled
// - stop flag after master frame
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module i2cam_top (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire i2cam_pkg::i2cam_req_t req,
  output logic [7:0]             rdata,
  input  wire logic              scl_in,
  output logic                   scl_out,
  output logic                   scl_oe,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic                  scl_s;
  logic                  sda_s;
  i2cam_pkg::i2cam_evt_t evt;
  i2cam_pkg::i2cam_mst_t mst_q;
  i2cam_pkg::i2cam_mst_t mst_d;
  i2cam_pkg::i2cam_slv_t slv_q;
  i2cam_pkg::i2cam_slv_t slv_d;
  logic [7:0] addr_fmt_q;
  logic [7:0] tx_hold_q;
  logic [7:0] rx_hold_q;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [7:0] flag_q;
  logic [7:0] flag_d;
  logic [7:0] armed_q;
  logic [7:0] flag_set;
  logic [7:0] hw_clr;
  logic [7:0] sw_clr;
  logic [7:0] rd_mux;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [9:0] tmr_q;
  logic       sh_full_q;
  logic       enable_q;
  logic       master_q;
  logic       transmit_q;
  logic       order_q;
  logic       ack_chk_q;
  logic       rx_ack_q;
  logic       stop_req_q;
  logic       xfer_q;
  logic       addr_ph_q;

  // register port decode
  logic wr_addr_fmt, wr_tx, wr_status, wr_ctl1, wr_ctl2, wr_mode, wr_ien;
  logic rd_rx, rd_status;
  // bus-side events
  logic half_done, bit_end, ack_rise, byte_end, sh_load;
  logic start_go, stop_go, stop_seen, mst_active;
  logic slv_on, slv_shift, byte_in, addr_hit, gc_hit, match_ev, rx_load;
  logic ack_end, scl_low_m, sda_low_m;

  ////////////////////////////////////////////////////////////////////////////
  // pin conditioning and bus watching
  i2cam_pin_sync u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .scl_s    (scl_s),
    .sda_s    (sda_s)
  );

  i2cam_bus_mon u_mon (
    .core_clk (core_clk),
    .rst      (rst),
    .scl_s    (scl_s),
    .sda_s    (sda_s),
    .evt      (evt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register port decode
  assign wr_addr_fmt = req.wr & (req.addr == i2cam_pkg::OFS_ADDR_FMT);
  assign wr_tx       = req.wr & (req.addr == i2cam_pkg::OFS_TX_DATA);
  assign wr_status   = req.wr & (req.addr == i2cam_pkg::OFS_STATUS);
  assign wr_ctl1     = req.wr & (req.addr == i2cam_pkg::OFS_CTL_ONE);
  assign wr_ctl2     = req.wr & (req.addr == i2cam_pkg::OFS_CTL_TWO);
  assign wr_mode     = req.wr & (req.addr == i2cam_pkg::OFS_MODE);
  assign wr_ien      = req.wr & (req.addr == i2cam_pkg::OFS_IRQ_EN);
  assign rd_rx       = req.rd & (req.addr == i2cam_pkg::OFS_RX_DATA);
  assign rd_status   = req.rd & (req.addr == i2cam_pkg::OFS_STATUS);

  // read selection; the shifter has no address, unmapped reads give zero
  assign rd_mux =
    (req.addr == i2cam_pkg::OFS_ADDR_FMT) ? addr_fmt_q :
    (req.addr == i2cam_pkg::OFS_TX_DATA)  ? (order_q ? i2cam_pkg::rev8(tx_hold_q) : tx_hold_q) :
    (req.addr == i2cam_pkg::OFS_RX_DATA)  ? rx_hold_q :
    (req.addr == i2cam_pkg::OFS_STATUS)   ? flag_q :
    (req.addr == i2cam_pkg::OFS_CTL_ONE)  ? ({7'h00, enable_q} << i2cam_pkg::C1_ENABLE)
                                          | ({7'h00, master_q} << i2cam_pkg::C1_MASTER)
                                          | ({7'h00, transmit_q} << i2cam_pkg::C1_TRANSMIT) :
    (req.addr == i2cam_pkg::OFS_CTL_TWO)  ? ({7'h00, evt.busy | mst_active} << i2cam_pkg::C2_BUSY) :
    (req.addr == i2cam_pkg::OFS_MODE)     ? ({7'h00, order_q} << i2cam_pkg::MODE_BIT_ORDER) :
    (req.addr == i2cam_pkg::OFS_IRQ_EN)   ? ({7'h00, ack_chk_q} << i2cam_pkg::IEN_ACK_CHECK)
                                          | ({7'h00, rx_ack_q} << i2cam_pkg::IEN_RX_ACK) :
    8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // master transmit sequencing
  assign half_done  = (tmr_q == 10'h000);
  assign mst_active = (mst_q != i2cam_pkg::M_IDLE);
  // start only from an idle, free bus in master transmit, two-wire format
  assign start_go = wr_ctl2 & req.wdata[i2cam_pkg::C2_BUSY] & ~req.wdata[i2cam_pkg::C2_START_STOP]
                  & enable_q & master_q & transmit_q & ~addr_fmt_q[i2cam_pkg::FMT_SEL_BIT]
                  & ~evt.busy & ~mst_active;
  assign stop_go  = wr_ctl2 & ~req.wdata[i2cam_pkg::C2_BUSY] & ~req.wdata[i2cam_pkg::C2_START_STOP]
                  & mst_active;
  assign bit_end  = (mst_q == i2cam_pkg::M_BIT_HI) & half_done;
  assign ack_rise = (mst_q == i2cam_pkg::M_ACK_LO) & half_done; // ninth SCL rise
  assign byte_end = (mst_q == i2cam_pkg::M_ACK_HI) & half_done;
  // empty shifter takes the holding byte only in M_START or M_HOLD, so SCL stays low between bytes until it loads
  assign sh_load  = ~sh_full_q & ~flag_q[i2cam_pkg::ST_TX_EMPTY]
                  & ((mst_q == i2cam_pkg::M_START) | (mst_q == i2cam_pkg::M_HOLD));
  assign stop_seen = evt.stop & xfer_q;

  // master state transitions; each timed state lasts half an SCL period
  always_comb begin
    mst_d = mst_q;
    case (mst_q)
      i2cam_pkg::M_IDLE:     if (start_go) mst_d = i2cam_pkg::M_START;
      i2cam_pkg::M_START:    if (half_done) mst_d = i2cam_pkg::M_HOLD;
      i2cam_pkg::M_HOLD: begin
        if (stop_req_q) mst_d = i2cam_pkg::M_STOP_LO;
        else if (sh_full_q) mst_d = i2cam_pkg::M_BIT_LO;
      end
      i2cam_pkg::M_BIT_LO:   if (half_done) mst_d = i2cam_pkg::M_BIT_HI;
      i2cam_pkg::M_BIT_HI: begin
        if (half_done) mst_d = (cnt_q == i2cam_pkg::LAST_BIT) ? i2cam_pkg::M_ACK_LO : i2cam_pkg::M_BIT_LO;
      end
      i2cam_pkg::M_ACK_LO:   if (half_done) mst_d = i2cam_pkg::M_ACK_HI;
      i2cam_pkg::M_ACK_HI:   if (half_done) mst_d = i2cam_pkg::M_HOLD;
      i2cam_pkg::M_STOP_LO:  if (half_done) mst_d = i2cam_pkg::M_STOP_HI;
      i2cam_pkg::M_STOP_HI:  if (half_done) mst_d = i2cam_pkg::M_STOP_REL;
      i2cam_pkg::M_STOP_REL: if (half_done) mst_d = i2cam_pkg::M_IDLE;
      default:               mst_d = i2cam_pkg::M_IDLE;
    endcase
  end

  // pin drive from the master: SCL low while waiting keeps the slave paced
  assign scl_low_m = (mst_q == i2cam_pkg::M_HOLD) | (mst_q == i2cam_pkg::M_BIT_LO)
                   | (mst_q == i2cam_pkg::M_ACK_LO) | (mst_q == i2cam_pkg::M_STOP_LO);
  // SDA falls with SCL high for start, rises with SCL high for stop
  assign sda_low_m = (mst_q == i2cam_pkg::M_START) | (mst_q == i2cam_pkg::M_STOP_LO)
                   | (mst_q == i2cam_pkg::M_STOP_HI)
                   | (((mst_q == i2cam_pkg::M_BIT_LO) | (mst_q == i2cam_pkg::M_BIT_HI)) & ~shift_q[7]);

  ////////////////////////////////////////////////////////////////////////////
  // slave receive: address phase and data bytes
  assign slv_on    = enable_q & ~master_q & ~transmit_q & ~addr_fmt_q[i2cam_pkg::FMT_SEL_BIT];
  assign slv_shift = evt.scl_rise & ((slv_q == i2cam_pkg::S_ADDR) | (slv_q == i2cam_pkg::S_DATA))
                   & (cnt_q != i2cam_pkg::FRAME_BITS);
  assign byte_in   = evt.scl_fall & ((slv_q == i2cam_pkg::S_ADDR) | (slv_q == i2cam_pkg::S_DATA))
                   & (cnt_q == i2cam_pkg::FRAME_BITS);
  assign gc_hit    = (shift_q[7:1] == i2cam_pkg::GEN_CALL_ADDR);
  assign addr_hit  = (shift_q[7:1] == addr_fmt_q[i2cam_pkg::ADDR_MSB:i2cam_pkg::ADDR_LSB]) | gc_hit;
  assign match_ev  = byte_in & (slv_q == i2cam_pkg::S_ADDR) & addr_hit;
  assign rx_load   = match_ev | (byte_in & (slv_q == i2cam_pkg::S_DATA));
  assign ack_end   = (slv_q == i2cam_pkg::S_ACK) & evt.scl_fall;

  // slave states; a read request (direction one) is not served here
  always_comb begin
    slv_d = slv_q;
    if (!slv_on) begin
      slv_d = i2cam_pkg::S_IDLE;
    end else if (evt.start) begin
      slv_d = i2cam_pkg::S_ADDR;
    end else if (evt.stop) begin
      slv_d = i2cam_pkg::S_IDLE;
    end else begin
      case (slv_q)
        i2cam_pkg::S_IDLE: slv_d = i2cam_pkg::S_IDLE;
        i2cam_pkg::S_SKIP: slv_d = i2cam_pkg::S_SKIP;
        i2cam_pkg::S_ADDR: if (byte_in) slv_d = addr_hit ? i2cam_pkg::S_ACK : i2cam_pkg::S_SKIP;
        i2cam_pkg::S_DATA: if (byte_in) slv_d = i2cam_pkg::S_ACK;
        i2cam_pkg::S_ACK: begin
          if (evt.scl_fall) slv_d = (addr_ph_q & shift_q[0]) ? i2cam_pkg::S_SKIP : i2cam_pkg::S_DATA;
        end
        default: slv_d = i2cam_pkg::S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared shifter and bit counter; master owns them while active
  always_comb begin
    shift_d = shift_q;
    cnt_d   = cnt_q;
    if (sh_load) begin
      shift_d = order_q ? i2cam_pkg::rev8(tx_hold_q) : tx_hold_q;
      cnt_d   = 4'h0;
    end else if (bit_end) begin
      shift_d = {shift_q[6:0], 1'b1};
      cnt_d   = cnt_q + 4'h1;
    end else if (evt.start | ack_end) begin
      cnt_d   = 4'h0;
    end else if (slv_shift) begin
      shift_d = {shift_q[6:0], sda_s};
      cnt_d   = cnt_q + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags: hardware set beats any clear in the same cycle
  assign flag_set[i2cam_pkg::ST_TX_EMPTY]   = sh_load | start_go;
  assign flag_set[i2cam_pkg::ST_TX_DONE]    = ack_rise & flag_q[i2cam_pkg::ST_TX_EMPTY];
  assign flag_set[i2cam_pkg::ST_RX_FULL]    = rx_load;
  assign flag_set[i2cam_pkg::ST_NO_ACK]     = byte_end & sda_s & ack_chk_q;
  assign flag_set[i2cam_pkg::ST_STOP]       = stop_seen;
  assign flag_set[2]                        = 1'b0;
  assign flag_set[i2cam_pkg::ST_ADDR_MATCH] = match_ev;
  assign flag_set[i2cam_pkg::ST_GEN_CALL]   = match_ev & gc_hit;

  // a tx write empties the holding flag and the done flag; an rx read drains
  assign hw_clr = ({7'h00, wr_tx} << i2cam_pkg::ST_TX_EMPTY)
                | ({7'h00, wr_tx} << i2cam_pkg::ST_TX_DONE)
                | ({7'h00, rd_rx} << i2cam_pkg::ST_RX_FULL);
  // zero clears only a bit seen as one; a written one is ignored
  assign sw_clr = {8{wr_status}} & ~req.wdata & armed_q & i2cam_pkg::ST_SW_CLR_MASK;
  assign flag_d = (flag_q & ~(sw_clr | hw_clr)) | flag_set;

  ////////////////////////////////////////////////////////////////////////////
  // registers written by software
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      addr_fmt_q <= i2cam_pkg::ADDR_FMT_RESET;
      tx_hold_q  <= i2cam_pkg::TX_DATA_RESET;
      order_q    <= 1'b0;
      ack_chk_q  <= 1'b0;
      enable_q   <= 1'b0;
    end else begin
      if (wr_addr_fmt) addr_fmt_q <= req.wdata;
      if (wr_tx) tx_hold_q <= req.wdata;
      if (wr_mode) order_q <= req.wdata[i2cam_pkg::MODE_BIT_ORDER];
      if (wr_ien) ack_chk_q <= req.wdata[i2cam_pkg::IEN_ACK_CHECK];
      if (wr_ctl1) enable_q <= req.wdata[i2cam_pkg::C1_ENABLE];
    end
  end

  // mode bits; a stop after a master frame returns to slave receive
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      master_q   <= 1'b0;
      transmit_q <= 1'b0;
    end else if (stop_seen) begin
      master_q   <= 1'b0;
      transmit_q <= 1'b0;
    end else if (wr_ctl1) begin
      master_q   <= req.wdata[i2cam_pkg::C1_MASTER];
      transmit_q <= req.wdata[i2cam_pkg::C1_TRANSMIT];
    end
  end

  // flags and their read arming
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flag_q  <= 8'h00;
      armed_q <= 8'h00;
    end else begin
      flag_q  <= flag_d;
      armed_q <= (armed_q | ({8{rd_status}} & flag_q)) & flag_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus engine state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mst_q   <= i2cam_pkg::M_IDLE;
      slv_q   <= i2cam_pkg::S_IDLE;
      tmr_q   <= i2cam_pkg::SCL_HALF_RELOAD;
      shift_q <= 8'hFF;
      cnt_q   <= 4'h0;
    end else begin
      mst_q   <= mst_d;
      slv_q   <= slv_d;
      tmr_q   <= (mst_d != mst_q) ? i2cam_pkg::SCL_HALF_RELOAD : (half_done ? tmr_q : tmr_q - 10'h001);
      shift_q <= shift_d;
      cnt_q   <= cnt_d;
    end
  end

  // shifter occupancy, acknowledge capture and stop request
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sh_full_q  <= 1'b0;
      rx_ack_q   <= 1'b0;
      stop_req_q <= 1'b0;
      xfer_q     <= 1'b0;
    end else begin
      sh_full_q  <= sh_load | (sh_full_q & ~byte_end) ;
      if (byte_end) rx_ack_q <= sda_s;
      stop_req_q <= stop_go | (stop_req_q & (mst_q != i2cam_pkg::M_STOP_LO));
      xfer_q     <= byte_end | (xfer_q & ~evt.stop);
    end
  end

  // received byte hand-off; software cannot write this register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_hold_q <= i2cam_pkg::RX_DATA_RESET;
      addr_ph_q <= 1'b0;
    end else begin
      if (rx_load) rx_hold_q <= shift_q;
      addr_ph_q <= match_ev | (addr_ph_q & ~ack_end);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers and read data; open drain, so only the enables move
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      rdata  <= 8'h00;
    end else begin
      scl_oe <= scl_low_m;
      sda_oe <= sda_low_m | (slv_q == i2cam_pkg::S_ACK);
      rdata  <= req.rd ? rd_mux : 8'h00;
    end
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

endmodule : i2cam_top
`default_nettype wire
